// ### tib_pkg.sv
// Register map, field positions and sizes for the tag interrupt/buffer status
package tib_pkg;
    localparam logic [7:0] ADDR_IRQ_STATUS_ONE = 8'h0b;
    localparam logic [7:0] ADDR_BUFFER_FILL_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_BUFFER_FLAG_STATUS = 8'h0d;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Interrupt status bit positions
    localparam int IRQ_RX_START = 7;
    localparam int IRQ_FRAMING = 6;
    localparam int IRQ_PARITY = 5;
    localparam int IRQ_CHECKSUM = 4;
    localparam int IRQ_BUFFER = 3;
    localparam int IRQ_NV_DONE = 2;
    localparam int IRQ_MEM_ACCESS = 1;
    localparam int IRQ_CONFLICT = 0;
    // Fill status fields
    localparam int FILL_INVALID = 7;
    localparam int FILL_LEN_W = 6;
    // Flag status bit positions
    localparam int FLAG_RF_SIDE_BUSY = 5;
    localparam int FLAG_RF_READY = 4;
    localparam int FLAG_HOST_READY = 3;
    localparam int FLAG_UNDERFLOW = 1;
    localparam int FLAG_OVERFLOW = 0;
    // Data buffer geometry
    localparam int BUF_WIDTH = 8;
    localparam int BUF_DEPTH = 16;
    localparam int BUF_AW = 4;
endpackage

// ### tib_fifo.sv
// Flip-flop FIFO holding the shared tag data buffer
module tib_fifo
    import tib_pkg::*;
#(
    parameter int WIDTH = BUF_WIDTH,
    parameter int DEPTH = BUF_DEPTH,
    parameter int AW = BUF_AW
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Occupancy
    output logic [AW:0] count
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } tib_fifo_st_t;

    tib_fifo_st_t st, next_st;
    logic push, pop;

    // Handshakes combinational, data registered in storage
    assign in_ready = (st.cnt != DEPTH[AW:0]);
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rp];
    assign count = st.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (flush) begin
            next_st.wp = '0;
            next_st.rp = '0;
            next_st.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ### tib_status.sv
// Second interrupt status and buffer status registers of the tag front end
// Operation
// (R1) Reading an interrupt status register clears all its bits.
// (R2) Interrupt status resets to zero at power-up and set-default.
// (R3) Receive start into buffer sets bit 7.
// (R4) Framing fault sets bit 6; data still buffered.
// (R5) Parity fault sets bit 5; data still buffered.
// (R6) CRC fault sets bit 4; data still buffered.
// (R7) Buffer overflow or underflow sets bit 3.
// (R8) Host-requested nonvolatile write success sets bit 2.
// (R9) Write to protected or missing address sets bit 1.
// (R10) Host operation cut by access control sets bit 0.
// (R11) Length-invalid bit 7 high while buffer contents change.
// (R12) Six-bit unread byte count; bit 6 reads zero.
// (R13) Buffer status resets on power-up, set-default, clear-buffer.
// (R14) Flag register shows rf_side_busy, rf ready, host ready at 5,4,3.
// (R15) No host-busy flag in the flag register.
// (R16) Underflow bit 1 set when reading past buffer contents.
// (R17) Overflow bit 0 set when writing into a full buffer.
// (R18) Masking gates only the interrupt pin, never the flags.
// (R19) Interrupt pin high while any unmasked flag is set.
// (R20) Event coinciding with clearing read stays set.
module tib_status
    import tib_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Commands
    input wire logic cmd_set_default,
    input wire logic cmd_clear_buffer,
    // Host register read port
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    output logic [7:0] reg_rdata,
    // Interrupt mask and output
    input wire logic [7:0] irq_mask,
    output logic irq_out,
    // Receive events
    input wire logic rx_start,
    input wire logic rx_framing_err,
    input wire logic rx_parity_err,
    input wire logic rx_crc_err,
    // Memory events
    input wire logic nv_write_done_host,
    input wire logic nv_access_err,
    input wire logic access_conflict,
    // Extended mode handshake levels
    input wire logic rf_side_busy,
    input wire logic rf_data_ready,
    input wire logic host_data_ready,
    // Buffer fill side
    input wire logic buf_wr,
    input wire logic [7:0] buf_wdata,
    output logic buf_wr_ready,
    // Buffer drain side
    input wire logic buf_rd,
    output logic buf_rd_valid,
    output logic [7:0] buf_rdata
);
    typedef struct packed {
        logic [7:0] irq;
        logic len_invalid;
        logic underflow;
        logic overflow;
        logic [7:0] rdata;
    } tib_st_t;

    tib_st_t st, next_st;
    logic [BUF_AW:0] fill;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic flush;
    logic ovr_evt, unf_evt;
    logic [7:0] irq_evt;

    // Decode of a host read address
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    assign flush = cmd_set_default || cmd_clear_buffer; // R13
    assign ovr_evt = buf_wr && !fifo_in_ready; // R17
    assign unf_evt = buf_rd && !fifo_out_valid; // R16
    assign buf_wr_ready = fifo_in_ready;
    assign buf_rd_valid = fifo_out_valid;

    // Data buffer; errored frames are stored like good ones
    tib_fifo #(
        .WIDTH(BUF_WIDTH),
        .DEPTH(BUF_DEPTH),
        .AW(BUF_AW)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .flush(flush),
        .in_valid(buf_wr),
        .in_ready(fifo_in_ready),
        .in_data(buf_wdata),
        .out_valid(fifo_out_valid),
        .out_ready(buf_rd),
        .out_data(buf_rdata),
        .count(fill)
    );

    // Event vector in register bit order
    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_RX_START] = rx_start; // R3
        irq_evt[IRQ_FRAMING] = rx_framing_err; // R4
        irq_evt[IRQ_PARITY] = rx_parity_err; // R5
        irq_evt[IRQ_CHECKSUM] = rx_crc_err; // R6
        irq_evt[IRQ_BUFFER] = ovr_evt || unf_evt; // R7
        irq_evt[IRQ_NV_DONE] = nv_write_done_host; // R8
        irq_evt[IRQ_MEM_ACCESS] = nv_access_err; // R9
        irq_evt[IRQ_CONFLICT] = access_conflict; // R10
    end

    // Next state: clear-on-read loses to a fresh event
    always_comb begin
        next_st = st;
        if (reg_rd && hit(reg_addr, ADDR_IRQ_STATUS_ONE)) begin
            next_st.irq = REG_RESET; // R1
        end
        next_st.irq = next_st.irq | irq_evt; // R18 R20
        next_st.len_invalid = buf_wr || buf_rd; // R11
        if (ovr_evt) begin
            next_st.overflow = 1'b1; // R17
        end
        if (unf_evt) begin
            next_st.underflow = 1'b1; // R16
        end
        if (flush) begin
            next_st.len_invalid = 1'b0; // R13
            next_st.underflow = 1'b0;
            next_st.overflow = 1'b0;
        end
        if (cmd_set_default) begin
            next_st.irq = REG_RESET; // R2
        end
        // Read data captured so reg_rdata comes from a flip-flop
        next_st.rdata = REG_RESET;
        if (hit(reg_addr, ADDR_IRQ_STATUS_ONE)) begin
            next_st.rdata = st.irq;
        end else if (hit(reg_addr, ADDR_BUFFER_FILL_STATUS)) begin
            next_st.rdata[FILL_INVALID] = st.len_invalid; // R11
            next_st.rdata[FILL_LEN_W-1:0] = FILL_LEN_W'(fill); // R12
        end else if (hit(reg_addr, ADDR_BUFFER_FLAG_STATUS)) begin
            // Host-busy omitted: always idle while this is read
            next_st.rdata[FLAG_RF_SIDE_BUSY] = rf_side_busy; // R14 R15
            next_st.rdata[FLAG_RF_READY] = rf_data_ready;
            next_st.rdata[FLAG_HOST_READY] = host_data_ready;
            next_st.rdata[FLAG_UNDERFLOW] = st.underflow;
            next_st.rdata[FLAG_OVERFLOW] = st.overflow;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '0; // R2 R13
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign irq_out = |(st.irq & ~irq_mask); // R19

    // Clear on read; set-default beats every event
    a_read_clears_irq: assert property (@(posedge core_clk) // R1
        disable iff (!rstn)
        reg_rd && reg_addr == ADDR_IRQ_STATUS_ONE && !cmd_set_default
        |=> st.irq == $past(irq_evt))
        else $error("irq status not cleared by read");
    a_irq_read_data: assert property (@(posedge core_clk) // R1
        disable iff (!rstn)
        reg_addr == ADDR_IRQ_STATUS_ONE
        |=> reg_rdata == $past(st.irq))
        else $error("irq status read data wrong");
    a_irq_only_read: assert property (@(posedge core_clk) // R1
        disable iff (!rstn)
        !(reg_rd && reg_addr == ADDR_IRQ_STATUS_ONE) && !cmd_set_default
        |=> (st.irq & $past(st.irq)) == $past(st.irq))
        else $error("irq flag dropped without a read");
    a_default_clears: assert property (@(posedge core_clk) // R2
        disable iff (!rstn)
        cmd_set_default
        |=> st.irq == 8'h00)
        else $error("set default left irq bits");
    a_reset_clears: assert property (@(posedge core_clk) // R2
        !rstn
        |=> st.irq == 8'h00 && fill == '0 && reg_rdata == 8'h00)
        else $error("reset left state behind");
    a_event_kept: assert property (@(posedge core_clk) // R20
        disable iff (!rstn)
        reg_rd && reg_addr == ADDR_IRQ_STATUS_ONE && access_conflict
        && !cmd_set_default |=> st.irq[IRQ_CONFLICT])
        else $error("event lost on clearing read");

    // Each event sets its own flag; masks never hold a flag back
    a_rx_start_flag: assert property (@(posedge core_clk) // R3
        disable iff (!rstn)
        rx_start && !cmd_set_default
        |=> st.irq[IRQ_RX_START])
        else $error("rx start flag missing");
    a_framing_flag: assert property (@(posedge core_clk) // R4
        disable iff (!rstn)
        rx_framing_err && !cmd_set_default
        |=> st.irq[IRQ_FRAMING])
        else $error("framing flag missing");
    a_parity_flag: assert property (@(posedge core_clk) // R5
        disable iff (!rstn)
        rx_parity_err && !cmd_set_default
        |=> st.irq[IRQ_PARITY])
        else $error("parity flag missing");
    a_crc_flag: assert property (@(posedge core_clk) // R6
        disable iff (!rstn)
        rx_crc_err && !cmd_set_default
        |=> st.irq[IRQ_CHECKSUM])
        else $error("crc flag missing");
    a_crc_flag_masked: assert property (@(posedge core_clk) // R18
        disable iff (!rstn)
        rx_crc_err && irq_mask[IRQ_CHECKSUM] && !cmd_set_default
        |=> st.irq[IRQ_CHECKSUM])
        else $error("masked crc event not flagged");
    a_nv_done_flag: assert property (@(posedge core_clk) // R8
        disable iff (!rstn)
        nv_write_done_host && !cmd_set_default
        |=> st.irq[IRQ_NV_DONE])
        else $error("nonvolatile done flag missing");
    a_mem_access_flag: assert property (@(posedge core_clk) // R9
        disable iff (!rstn)
        nv_access_err && !cmd_set_default
        |=> st.irq[IRQ_MEM_ACCESS])
        else $error("memory access flag missing");
    a_conflict_flag: assert property (@(posedge core_clk) // R10
        disable iff (!rstn)
        access_conflict && !cmd_set_default
        |=> st.irq[IRQ_CONFLICT])
        else $error("access conflict flag missing");
    a_buffer_flag: assert property (@(posedge core_clk) // R7
        disable iff (!rstn)
        buf_rd && !buf_rd_valid && !cmd_set_default
        |=> st.irq[IRQ_BUFFER])
        else $error("buffer error flag missing");
    a_irq_no_spurious: assert property (@(posedge core_clk) // R3
        disable iff (!rstn)
        irq_evt == 8'h00
        |=> (st.irq & ~$past(st.irq)) == 8'h00)
        else $error("irq flag rose without event");

    // Pin drops with a clean read, rises with an unmasked flag
    a_irq_pin: assert property (@(posedge core_clk) // R19
        disable iff (!rstn)
        reg_rd && reg_addr == ADDR_IRQ_STATUS_ONE && irq_evt == 8'h00
        |=> !irq_out)
        else $error("irq pin stuck after read");
    a_unmasked_pin: assert property (@(posedge core_clk) // R19
        disable iff (!rstn)
        rx_start && !irq_mask[IRQ_RX_START] && !cmd_set_default
        ##1 !irq_mask[IRQ_RX_START] |-> irq_out)
        else $error("irq pin missing for unmasked flag");

    // Sticky buffer faults; a refused byte leaves the count alone
    a_overflow_sets: assert property (@(posedge core_clk) // R17
        disable iff (!rstn)
        buf_wr && !buf_wr_ready && !flush
        |=> st.overflow && st.irq[IRQ_BUFFER])
        else $error("overflow not flagged");
    a_overflow_sticky: assert property (@(posedge core_clk) // R17
        disable iff (!rstn)
        st.overflow && !flush
        |=> st.overflow)
        else $error("overflow flag dropped");
    a_full_drops: assert property (@(posedge core_clk) // R17
        disable iff (!rstn)
        buf_wr && !buf_wr_ready && !buf_rd && !flush
        |=> fill == $past(fill))
        else $error("write into full buffer changed count");
    a_underflow_sets: assert property (@(posedge core_clk) // R16
        disable iff (!rstn)
        buf_rd && !buf_rd_valid && !flush
        |=> st.underflow)
        else $error("underflow not flagged");
    a_underflow_sticky: assert property (@(posedge core_clk) // R16
        disable iff (!rstn)
        st.underflow && !flush
        |=> st.underflow)
        else $error("underflow flag dropped");
    a_empty_stays: assert property (@(posedge core_clk) // R16
        disable iff (!rstn)
        buf_rd && !buf_rd_valid && !buf_wr && !flush
        |=> fill == '0)
        else $error("read of empty buffer changed count");
    a_flush_clears: assert property (@(posedge core_clk) // R13
        disable iff (!rstn)
        cmd_clear_buffer
        |=> !st.overflow && !st.underflow && fill == '0)
        else $error("clear buffer left status");
    a_default_buffer: assert property (@(posedge core_clk) // R13
        disable iff (!rstn)
        cmd_set_default
        |=> !st.overflow && !st.underflow && !st.len_invalid && fill == '0)
        else $error("set default left buffer status");

    // Count field; a read right after a strobe flags it stale
    a_fill_read: assert property (@(posedge core_clk) // R12
        disable iff (!rstn)
        reg_addr == ADDR_BUFFER_FILL_STATUS
        |=> reg_rdata[6:0] == {2'b00, $past(fill)})
        else $error("fill count read wrong");
    a_fill_push: assert property (@(posedge core_clk) // R12
        disable iff (!rstn)
        buf_wr && buf_wr_ready && !buf_rd && !flush
        |=> fill == $past(fill) + 5'd1)
        else $error("fill count missed a push");
    a_fill_pop: assert property (@(posedge core_clk) // R12
        disable iff (!rstn)
        buf_rd && buf_rd_valid && !buf_wr && !flush
        |=> fill == $past(fill) - 5'd1)
        else $error("fill count missed a pop");
    a_fill_bound: assert property (@(posedge core_clk) // R12
        disable iff (!rstn)
        fill <= BUF_DEPTH)
        else $error("fill count beyond buffer depth");
    a_len_invalid_set: assert property (@(posedge core_clk) // R11
        disable iff (!rstn)
        (buf_wr || buf_rd) && !flush
        |=> st.len_invalid)
        else $error("length invalid not raised");
    a_len_invalid_idle: assert property (@(posedge core_clk) // R11
        disable iff (!rstn)
        !buf_wr && !buf_rd
        |=> !st.len_invalid)
        else $error("length invalid stuck high");
    a_fill_invalid_bit: assert property (@(posedge core_clk) // R11
        disable iff (!rstn)
        (buf_wr || buf_rd) && !flush ##1 reg_addr == ADDR_BUFFER_FILL_STATUS
        |=> reg_rdata[FILL_INVALID])
        else $error("stale count not marked invalid");

    // Flag register: live handshake levels, no host-busy bit
    a_flag_levels: assert property (@(posedge core_clk) // R14
        disable iff (!rstn)
        reg_addr == ADDR_BUFFER_FLAG_STATUS
        |=> reg_rdata[5:3] == $past({rf_side_busy, rf_data_ready, host_data_ready}))
        else $error("handshake levels read wrong");
    a_flag_reserved: assert property (@(posedge core_clk) // R15
        disable iff (!rstn)
        reg_addr == ADDR_BUFFER_FLAG_STATUS
        |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[2])
        else $error("unused flag bits not zero");
endmodule

// ### tib_host.sv
// Host microcontroller model issuing register reads
module tib_host (
    // Clock
    input wire logic core_clk,
    // Bench request
    input wire logic req,
    input wire logic [7:0] req_addr,
    // Register port
    output logic reg_rd,
    output logic [7:0] reg_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] idle = 8'h00;
    // Idle address wanders so a stale value never looks like a request
    always @(posedge core_clk) idle <= idle + 8'h3d;
    assign reg_rd = req;
    assign reg_addr = req ? req_addr : idle;
endmodule

// ### tag_irq_and_buffer_status_tb.sv
// Self-checking bench for the tag interrupt and buffer status block
module tag_irq_and_buffer_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rstn, sd, cb, req, reg_rd, irq_out, wr, pop, wrdy, rval;
    logic [7:0] req_addr, reg_addr, rdata, mask, wdata, bdata;
    logic [6:0] ev;
    logic [2:0] lv;
    logic pend = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] dq[$];
    logic [7:0] irqb[7] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h40, 8'h80};
    logic [31:0] seed = 32'haa8e93c3;
    int errors = 0;
    int checks_done = 0;

    tib_host host (.core_clk(core_clk), .req(req), .req_addr(req_addr),
        .reg_rd(reg_rd), .reg_addr(reg_addr));
    tib_status DUT (.core_clk(core_clk), .rstn(rstn), .cmd_set_default(sd),
        .cmd_clear_buffer(cb), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata(rdata), .irq_mask(mask), .irq_out(irq_out),
        .rx_start(ev[6]), .rx_framing_err(ev[5]), .rx_parity_err(ev[4]),
        .rx_crc_err(ev[3]), .nv_write_done_host(ev[2]),
        .nv_access_err(ev[1]), .access_conflict(ev[0]),
        .rf_side_busy(lv[2]), .rf_data_ready(lv[1]),
        .host_data_ready(lv[0]), .buf_wr(wr), .buf_wdata(wdata),
        .buf_wr_ready(wrdy), .buf_rd(pop), .buf_rd_valid(rval),
        .buf_rdata(bdata));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One cycle of stimulus; a read also notes its expected answer
    task automatic step(input logic r, input logic [7:0] a, input logic w,
        input logic p, input logic [6:0] e, input logic [7:0] x);
        req = r;
        req_addr = a;
        wr = w;
        pop = p;
        ev = e;
        if (r) exp_q.push_back(x);
        @(negedge core_clk);
    endtask

    task automatic stop_test;
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Read data lands one edge after the request; compare oldest note
    always @(posedge core_clk) pend <= req;
    always @(negedge core_clk) begin
        if (pend) chk(rdata, exp_q.pop_front());
    end

    // Whole run is under a hundred cycles
    initial begin
        #8000;
        errors++;
        stop_test();
    end

    initial begin
        {rstn, sd, cb, req, wr, pop, ev, lv} = '0;
        {req_addr, mask, wdata} = '0;
        repeat (8) @(negedge core_clk);
        rstn = 1'b1;
        step(1, 8'h0b, 0, 0, 0, 8'h00);
        step(1, 8'h0c, 0, 0, 0, 8'h00);
        step(1, 8'h0d, 0, 0, 0, 8'h00);
        step(1, 8'h3f, 0, 0, 0, 8'h00);
        // Each event in its own bit, masked or not, cleared by reading
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            mask = seed[7:0];
            step(0, 8'h00, 0, 0, 7'h01 << i, 8'h00);
            chk({7'h00, irq_out}, {7'h00, ~|(irqb[i] & mask)});
            step(1, 8'h0b, 0, 0, 0, irqb[i]);
            step(1, 8'h0b, 0, 0, 0, 8'h00);
            chk({7'h00, irq_out}, 8'h00);
        end
        mask = 8'h00;
        step(1, 8'h0b, 0, 0, 7'h40, 8'h00);
        step(1, 8'h0b, 0, 0, 0, 8'h80);
        step(0, 8'h00, 0, 0, 7'h01, 8'h00);
        sd = 1'b1;
        step(0, 8'h00, 0, 0, 0, 8'h00);
        sd = 1'b0;
        step(1, 8'h0b, 0, 0, 0, 8'h00);
        step(0, 8'h00, 1, 0, 0, 8'h00);
        step(1, 8'h0c, 0, 0, 0, 8'h81);
        step(1, 8'h0c, 0, 0, 0, 8'h01);
        // Fill to the brim, then one more byte than fits
        for (int i = 0; i < 15; i++) begin
            seed = lfsr(seed);
            wdata = seed[7:0];
            dq.push_back(seed[7:0]);
            step(0, 8'h00, 1, 0, 0, 8'h00);
        end
        step(0, 8'h00, 0, 0, 0, 8'h00);
        step(1, 8'h0c, 0, 0, 0, 8'h10);
        chk({7'h00, wrdy}, 8'h00);
        step(0, 8'h00, 1, 0, 0, 8'h00);
        step(1, 8'h0d, 0, 0, 0, 8'h01);
        step(1, 8'h0b, 0, 0, 0, 8'h08);
        chk({7'h00, rval}, 8'h01);
        chk(bdata, 8'h00);
        step(0, 8'h00, 0, 1, 0, 8'h00);
        for (int i = 0; i < 15; i++) begin
            chk(bdata, dq.pop_front());
            step(0, 8'h00, 0, 1, 0, 8'h00);
        end
        step(0, 8'h00, 0, 0, 0, 8'h00);
        chk({7'h00, rval}, 8'h00);
        step(1, 8'h0c, 0, 0, 0, 8'h00);
        step(0, 8'h00, 0, 1, 0, 8'h00);
        step(1, 8'h0d, 0, 0, 0, 8'h03);
        step(1, 8'h0b, 0, 0, 0, 8'h08);
        cb = 1'b1;
        step(0, 8'h00, 1, 0, 0, 8'h00);
        cb = 1'b0;
        step(0, 8'h00, 0, 0, 0, 8'h00);
        step(1, 8'h0c, 0, 0, 0, 8'h00);
        // Every combination of the handshake levels
        for (int j = 0; j < 8; j++) begin
            lv = j[2:0];
            step(1, 8'h0d, 0, 0, 0, {2'b00, j[2:0], 3'b000});
        end
        step(0, 8'h00, 0, 0, 0, 8'h00);
        step(0, 8'h00, 0, 0, 0, 8'h00);
        stop_test();
    end
endmodule
